// ===== core/sc_pkg.sv
package sc_pkg;
  // register map, byte addresses
  localparam logic [2:0] STAT_OFS = 3'h0;
  localparam logic [2:0] CTRL_OFS = 3'h1;
  localparam logic [2:0] DATA_OFS = 3'h2;
  localparam logic [2:0] ISO_OFS = 3'h3;
  localparam logic [2:0] ETU_OFS = 3'h4;
  localparam logic [2:0] QUEUE_OFS = 3'h5;
  localparam logic [2:0] NLIM_OFS = 3'h6;
  // status fields
  localparam int ST_TRANSMIT_BUFFER_EMPTY_FLAG = 7;
  localparam int ST_TC = 6;
  localparam int ST_RDRF = 5;
  localparam int ST_NF = 2;
  localparam int ST_FE = 1;
  localparam int ST_PE = 0;
  // control fields
  localparam int CT_TE = 0;
  localparam int CT_RE = 1;
  localparam int CT_DIR = 2;
  localparam int CT_MSB_FIRST_SELECT = 3;
  localparam int CT_RECEIVE_INVERT = 4;
  localparam int CT_TRANSMIT_INVERT = 5;
  localparam int CT_T1 = 6;
  // iso status and queue fields
  localparam int ISO_NACKT = 0;
  localparam int Q_PRE = 0;
  localparam int Q_BRK = 1;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ETU_RST = 8'h10;
  localparam logic [7:0] NLIM_RST = 8'h03;
  // frame timing in etu
  localparam logic [3:0] FRAME_BITS = 4'h9;
  localparam logic [1:0] GUARD_T0 = 2'h2;
  localparam logic [1:0] GUARD_T1 = 2'h1;
  localparam logic [1:0] RX_STOP_T0 = 2'h1;
  localparam logic [1:0] RX_STOP_T1 = 2'h2;

  typedef enum logic [1:0] {TXK_DATA = 2'h0, TXK_PRE = 2'h1, TXK_BRK = 2'h2} tx_kind_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic perr;
    logic ferr;
    logic noise;
  } rx_event_type;

  typedef struct packed {
    logic done;
    logic nack;
    logic busy;
  } tx_status_type;

  function automatic logic [7:0] reverse8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      reverse8[i] = v[7 - i];
    end
  endfunction
endpackage

// ===== core/sc_rx.sv
`timescale 1ns/1ps
module sc_rx (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // configuration
  input wire logic enable_i,
  input wire logic t1_i,
  input wire logic inv_i,
  input wire logic msb_first_select_i,
  input wire logic [7:0] etu_i,
  // line, already synchronised
  input wire logic line_i,
  // received character
  output sc_pkg::rx_event_type ev_o
);
  typedef enum logic [2:0] {IDLE = 3'b001, BITS = 3'b010, STOP = 3'b100} rx_state_type;
  rx_state_type state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [3:0] bit_q, bit_d;
  logic [9:0] sh_q, sh_d;
  logic smp_q, smp_d;
  logic noise_q, noise_d;
  logic ferr_q, ferr_d;
  sc_pkg::rx_event_type ev_d;
  logic tick, mid, after;
  logic [9:0] v;

  assign tick = cnt_q == etu_i - 8'h01;
  assign mid = cnt_q == {1'b0, etu_i[7:1]};
  assign after = cnt_q == {1'b0, etu_i[7:1]} + 8'h01;
  assign v = inv_i ? ~sh_q : sh_q;

  always_comb begin
    state_d = state_q;
    cnt_d = tick ? 8'h00 : cnt_q + 8'h01;
    bit_d = bit_q;
    sh_d = sh_q;
    smp_d = mid ? line_i : smp_q;
    noise_d = noise_q | (after && line_i != smp_q);
    ferr_d = ferr_q;
    ev_d = '0;
    case (state_q)
      IDLE: begin
        cnt_d = 8'h00;
        bit_d = 4'h0;
        noise_d = 1'b0;
        ferr_d = 1'b0;
        if (enable_i && !line_i) begin
          state_d = BITS;
        end
      end
      BITS: begin
        if (mid) begin
          sh_d = {line_i, sh_q[9:1]};
          if (bit_q == 4'h0 && line_i) begin
            state_d = IDLE;
          end
        end
        if (tick) begin
          bit_d = bit_q + 4'h1;
          if (bit_q == sc_pkg::FRAME_BITS) begin
            state_d = STOP;
            bit_d = 4'h0;
          end
        end
      end
      STOP: begin
        // one stop etu short in t1 means the frame is seen as broken
        if (mid && !line_i) begin
          ferr_d = 1'b1;
        end
        if (tick) begin
          bit_d = bit_q + 4'h1;
          if (bit_q[1:0] == (t1_i ? sc_pkg::RX_STOP_T1 : sc_pkg::RX_STOP_T0) - 2'h1) begin
            state_d = IDLE;
            ev_d.valid = 1'b1;
            ev_d.data = msb_first_select_i ? sc_pkg::reverse8(v[8:1]) : v[8:1];
            ev_d.perr = ^v[9:1];
            ev_d.ferr = ferr_d;
            ev_d.noise = noise_q;
          end
        end
      end
      default: state_d = IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_q <= IDLE;
      cnt_q <= 8'h00;
      bit_q <= 4'h0;
      sh_q <= 10'h000;
      smp_q <= 1'b1;
      noise_q <= 1'b0;
      ferr_q <= 1'b0;
      ev_o <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      smp_q <= smp_d;
      noise_q <= noise_d;
      ferr_q <= ferr_d;
      ev_o <= ev_d;
    end
  end
endmodule

// ===== core/sc_tx.sv
`timescale 1ns/1ps
module sc_tx (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // request
  input wire logic start_i,
  input wire sc_pkg::tx_kind_type kind_i,
  input wire logic [7:0] data_i,
  input wire logic t1_i,
  input wire logic inv_i,
  input wire logic msb_first_select_i,
  input wire logic [7:0] etu_i,
  // line
  input wire logic line_i,
  output logic drive_o,
  output logic level_o,
  // status
  output sc_pkg::tx_status_type stat_o
);
  typedef enum logic [2:0] {IDLE = 3'b001, SEND = 3'b010, GUARD = 3'b100} tx_state_type;
  tx_state_type state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [3:0] bit_q, bit_d;
  logic [9:0] shift_q, shift_d;
  logic chk_q, chk_d;
  logic drive_d, level_d;
  sc_pkg::tx_status_type stat_d;
  logic tick, mid;
  logic [7:0] ord;
  logic par;

  assign tick = cnt_q == etu_i - 8'h01;
  assign mid = cnt_q == {1'b0, etu_i[7:1]};
  assign ord = msb_first_select_i ? sc_pkg::reverse8(data_i) : data_i;
  assign par = ^data_i;

  always_comb begin
    state_d = state_q;
    cnt_d = tick ? 8'h00 : cnt_q + 8'h01;
    bit_d = bit_q;
    shift_d = shift_q;
    chk_d = chk_q;
    drive_d = 1'b0;
    level_d = 1'b1;
    stat_d = '0;
    case (state_q)
      IDLE: begin
        cnt_d = 8'h00;
        if (start_i) begin
          state_d = SEND;
          bit_d = 4'h0;
          chk_d = (kind_i == sc_pkg::TXK_DATA) && !t1_i;
          case (kind_i)
            sc_pkg::TXK_PRE: shift_d = 10'h3ff;
            sc_pkg::TXK_BRK: shift_d = 10'h000;
            default: shift_d = inv_i ? {~par, ~ord, 1'b0} : {par, ord, 1'b0};
          endcase
        end
      end
      SEND: begin
        drive_d = 1'b1;
        level_d = shift_q[0];
        if (tick) begin
          shift_d = {1'b1, shift_q[9:1]};
          bit_d = bit_q + 4'h1;
          // parity keeps its full etu; the release happens in guard
          if (bit_q == sc_pkg::FRAME_BITS) begin
            state_d = GUARD;
            bit_d = 4'h0;
          end
        end
      end
      GUARD: begin
        // line released so the card can pull it low
        if (mid && chk_q && bit_q == 4'h0 && !line_i) begin
          stat_d.nack = 1'b1;
        end
        if (tick) begin
          bit_d = bit_q + 4'h1;
          if (bit_q[1:0] == (t1_i ? sc_pkg::GUARD_T1 : sc_pkg::GUARD_T0) - 2'h1) begin
            state_d = IDLE;
            stat_d.done = 1'b1;
          end
        end
      end
      default: state_d = IDLE;
    endcase
    stat_d.busy = state_d != IDLE;
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_q <= IDLE;
      cnt_q <= 8'h00;
      bit_q <= 4'h0;
      shift_q <= 10'h3ff;
      chk_q <= 1'b0;
      drive_o <= 1'b0;
      level_o <= 1'b1;
      stat_o <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      chk_q <= chk_d;
      drive_o <= drive_d;
      level_o <= level_d;
      stat_o <= stat_d;
    end
  end
endmodule

// ===== core/sc_uart.sv
`timescale 1ns/1ps
module sc_uart (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // card i/o line
  input wire logic io_i,
  output logic io_o,
  output logic io_oe_o
);
  logic io_s1_q, io_s2_q;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] etu_q, etu_d;
  logic [7:0] nlim_q, nlim_d;
  logic [7:0] txbuf_q, txbuf_d;
  logic txfull_q, txfull_d;
  logic [7:0] rxbuf_q, rxbuf_d;
  logic rdrf_q, rdrf_d;
  logic tc_q, tc_d;
  logic fe_q, fe_d;
  logic nf_q, nf_d;
  logic pe_q, pe_d;
  logic nackt_q, nackt_d;
  logic [7:0] ncnt_q, ncnt_d;
  logic tc_seen_q, tc_seen_d;
  logic tc_loose_q, tc_loose_d;
  logic fe_seen_q, fe_seen_d;
  logic pre_q, pre_d;
  logic brk_q, brk_d;
  logic start_q, start_d;
  sc_pkg::tx_kind_type kind_q, kind_d;
  logic [7:0] txdat_q, txdat_d;
  logic [7:0] rdata_d;
  logic io_d, io_oe_d;
  logic tx_drive, tx_level;
  sc_pkg::tx_status_type tx_stat;
  sc_pkg::rx_event_type rx_ev;
  logic te, re, t1;
  logic wr_stat, wr_ctrl, wr_data, wr_iso, wr_etu, wr_queue, wr_nlim;
  logic rd_stat, rd_data;
  logic q_clear, tc_clear;
  logic [7:0] status;

  function automatic logic hit(input logic en, input logic [2:0] a, input logic [2:0] ofs);
    hit = en && a == ofs;
  endfunction

  // second flop only is read; the first may be metastable
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      io_s1_q <= 1'b1;
      io_s2_q <= 1'b1;
    end else begin
      io_s1_q <= io_i;
      io_s2_q <= io_s1_q;
    end
  end

  assign te = ctrl_q[sc_pkg::CT_TE];
  assign re = ctrl_q[sc_pkg::CT_RE];
  assign t1 = ctrl_q[sc_pkg::CT_T1];
  assign wr_stat = hit(wr_i, addr_i, sc_pkg::STAT_OFS);
  assign wr_ctrl = hit(wr_i, addr_i, sc_pkg::CTRL_OFS);
  assign wr_data = hit(wr_i, addr_i, sc_pkg::DATA_OFS);
  assign wr_iso = hit(wr_i, addr_i, sc_pkg::ISO_OFS);
  assign wr_etu = hit(wr_i, addr_i, sc_pkg::ETU_OFS);
  assign wr_queue = hit(wr_i, addr_i, sc_pkg::QUEUE_OFS);
  assign wr_nlim = hit(wr_i, addr_i, sc_pkg::NLIM_OFS);
  assign rd_stat = hit(rd_i, addr_i, sc_pkg::STAT_OFS);
  assign rd_data = hit(rd_i, addr_i, sc_pkg::DATA_OFS);
  assign q_clear = wr_queue && (wdata_i[sc_pkg::Q_PRE] || wdata_i[sc_pkg::Q_BRK]);

  always_comb begin
    status = 8'h00;
    status[sc_pkg::ST_TRANSMIT_BUFFER_EMPTY_FLAG] = !txfull_q;
    status[sc_pkg::ST_TC] = tc_q;
    status[sc_pkg::ST_RDRF] = rdrf_q;
    status[sc_pkg::ST_NF] = nf_q;
    status[sc_pkg::ST_FE] = fe_q;
    status[sc_pkg::ST_PE] = pe_q;
  end

  // configuration and transmit queue
  always_comb begin
    ctrl_d = wr_ctrl ? wdata_i : ctrl_q;
    etu_d = wr_etu ? wdata_i : etu_q;
    nlim_d = wr_nlim ? wdata_i : nlim_q;
    txbuf_d = wr_data ? wdata_i : txbuf_q;
    txfull_d = txfull_q | wr_data;
    pre_d = pre_q | (wr_queue && wdata_i[sc_pkg::Q_PRE]);
    brk_d = brk_q | (wr_queue && wdata_i[sc_pkg::Q_BRK]);
    start_d = 1'b0;
    kind_d = kind_q;
    txdat_d = txdat_q;
    // one launch in flight at a time; start_q covers the busy flop latency
    if (te && !tx_stat.busy && !start_q) begin
      if (brk_q) begin
        start_d = 1'b1;
        kind_d = sc_pkg::TXK_BRK;
        brk_d = wr_queue && wdata_i[sc_pkg::Q_BRK];
      end else if (pre_q) begin
        start_d = 1'b1;
        kind_d = sc_pkg::TXK_PRE;
        pre_d = wr_queue && wdata_i[sc_pkg::Q_PRE];
      end else if (txfull_q) begin
        start_d = 1'b1;
        kind_d = sc_pkg::TXK_DATA;
        txdat_d = txbuf_q;
        txfull_d = wr_data;
      end
    end
  end

  // transmit-complete and nack bookkeeping
  always_comb begin
    tc_clear = (wr_data || q_clear) && (tc_seen_q || tc_loose_q);
    tc_seen_d = tc_seen_q;
    if (rd_stat && tc_q) begin
      tc_seen_d = 1'b1;
    end
    if (tc_clear) begin
      tc_seen_d = 1'b0;
    end
    tc_loose_d = tc_loose_q | (tc_clear && q_clear);
    tc_d = tc_q & ~tc_clear;
    if (tx_stat.done && !txfull_q && !brk_q && !pre_q) begin
      tc_d = 1'b1;
    end
    if (tx_stat.nack) begin
      tc_d = 1'b1;
    end
    ncnt_d = ncnt_q;
    if (tx_stat.nack) begin
      ncnt_d = ncnt_q + 8'h01;
    end
    if (!te) begin
      ncnt_d = 8'h00;
    end
    nackt_d = nackt_q;
    if (wr_iso && wdata_i[sc_pkg::ISO_NACKT]) begin
      nackt_d = 1'b0;
    end
    if (tx_stat.nack && te && ncnt_q + 8'h01 >= nlim_q) begin
      nackt_d = 1'b1;
    end
  end

  // receive path and error flags
  always_comb begin
    rxbuf_d = rxbuf_q;
    rdrf_d = rdrf_q & ~rd_data;
    fe_seen_d = fe_seen_q | (rd_stat && fe_q);
    fe_d = fe_q;
    nf_d = nf_q;
    pe_d = pe_q;
    if (rd_data && fe_seen_q) begin
      fe_seen_d = 1'b0;
      fe_d = 1'b0;
      nf_d = 1'b0;
      pe_d = 1'b0;
    end
    if (rx_ev.valid) begin
      nf_d = nf_d | rx_ev.noise;
      pe_d = pe_d | rx_ev.perr;
      fe_d = fe_d | rx_ev.ferr;
      if (!fe_q && !rx_ev.ferr) begin
        rxbuf_d = rx_ev.data;
        rdrf_d = 1'b1;
      end
    end
  end

  // read data and pin drive
  always_comb begin
    rdata_d = 8'h00;
    if (rd_i) begin
      case (addr_i)
        sc_pkg::STAT_OFS: rdata_d = status;
        sc_pkg::CTRL_OFS: rdata_d = ctrl_q;
        sc_pkg::DATA_OFS: rdata_d = rxbuf_q;
        sc_pkg::ISO_OFS: rdata_d = {7'h00, nackt_q};
        sc_pkg::ETU_OFS: rdata_d = etu_q;
        sc_pkg::NLIM_OFS: rdata_d = nlim_q;
        default: rdata_d = 8'h00;
      endcase
    end
    io_oe_d = tx_drive && ctrl_q[sc_pkg::CT_DIR];
    io_d = tx_level;
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ctrl_q <= sc_pkg::CTRL_RST;
      etu_q <= sc_pkg::ETU_RST;
      nlim_q <= sc_pkg::NLIM_RST;
      txbuf_q <= 8'h00;
      txfull_q <= 1'b0;
      rxbuf_q <= 8'h00;
      rdrf_q <= 1'b0;
      tc_q <= 1'b0;
      fe_q <= 1'b0;
      nf_q <= 1'b0;
      pe_q <= 1'b0;
      nackt_q <= 1'b0;
      ncnt_q <= 8'h00;
      tc_seen_q <= 1'b0;
      tc_loose_q <= 1'b0;
      fe_seen_q <= 1'b0;
      pre_q <= 1'b0;
      brk_q <= 1'b0;
      start_q <= 1'b0;
      kind_q <= sc_pkg::TXK_DATA;
      txdat_q <= 8'h00;
      rdata_o <= 8'h00;
      io_o <= 1'b1;
      io_oe_o <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      etu_q <= etu_d;
      nlim_q <= nlim_d;
      txbuf_q <= txbuf_d;
      txfull_q <= txfull_d;
      rxbuf_q <= rxbuf_d;
      rdrf_q <= rdrf_d;
      tc_q <= tc_d;
      fe_q <= fe_d;
      nf_q <= nf_d;
      pe_q <= pe_d;
      nackt_q <= nackt_d;
      ncnt_q <= ncnt_d;
      tc_seen_q <= tc_seen_d;
      tc_loose_q <= tc_loose_d;
      fe_seen_q <= fe_seen_d;
      pre_q <= pre_d;
      brk_q <= brk_d;
      start_q <= start_d;
      kind_q <= kind_d;
      txdat_q <= txdat_d;
      rdata_o <= rdata_d;
      io_o <= io_d;
      io_oe_o <= io_oe_d;
    end
  end

  sc_tx u_tx (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .start_i(start_q),
    .kind_i(kind_q),
    .data_i(txdat_q),
    .t1_i(t1),
    .inv_i(ctrl_q[sc_pkg::CT_TRANSMIT_INVERT]),
    .msb_first_select_i(ctrl_q[sc_pkg::CT_MSB_FIRST_SELECT]),
    .etu_i(etu_q),
    .line_i(io_s2_q),
    .drive_o(tx_drive),
    .level_o(tx_level),
    .stat_o(tx_stat)
  );

  // own transmission is not looped back into the receiver
  sc_rx u_rx (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .enable_i(re && !tx_stat.busy && !start_q),
    .t1_i(t1),
    .inv_i(ctrl_q[sc_pkg::CT_RECEIVE_INVERT]),
    .msb_first_select_i(ctrl_q[sc_pkg::CT_MSB_FIRST_SELECT]),
    .etu_i(etu_q),
    .line_i(io_s2_q),
    .ev_o(rx_ev)
  );
endmodule

// ===== sim/card_model.sv
`timescale 1ns/1ps
module card_model (
  // clock
  input wire logic mclk_i,
  // device side of the line
  input wire logic io_o,
  input wire logic io_oe_o,
  // resolved line
  output logic io_i
);
  localparam int ETU = int'(sc_pkg::ETU_RST);
  logic drv_low = 1'b0;
  logic nack_en = 1'b0;
  logic oe_q = 1'b0;
  int nack_cnt = 0;
  logic [9:0] rx_sh = 10'h000;
  int rx_t = 0;
  // capture the device frame at mid-bit while it drives the line
  always @(posedge mclk_i) begin
    if (!io_oe_o) begin
      rx_t <= 0;
    end else begin
      rx_t <= rx_t + 1;
      if (rx_t % ETU == ETU / 2) begin
        rx_sh <= {io_i, rx_sh[9:1]};
      end
    end
  end
  // open line with pull-up: released reads high, any low wins
  assign io_i = (io_oe_o ? io_o : 1'b1) && !drv_low && nack_cnt == 0;
  // when asked, refuse each character with one etu low in the guard time
  always @(posedge mclk_i) begin
    oe_q <= io_oe_o;
    if (oe_q && !io_oe_o && nack_en) begin
      nack_cnt <= ETU;
    end else if (nack_cnt != 0) begin
      nack_cnt <= nack_cnt - 1;
    end
  end
  // inverse card: msb first with every data and parity level complemented
  task automatic send(input logic [7:0] d, input logic inv, input logic bad_par, input int stops);
    logic [8:0] f;
    for (int i = 0; i < 8; i++) begin
      f[i] = inv ? !d[7 - i] : d[i];
    end
    f[8] = ^d ^ bad_par ^ inv;
    drv_low <= 1'b1;
    repeat (ETU) @(posedge mclk_i);
    for (int i = 0; i < 9; i++) begin
      drv_low <= !f[i];
      repeat (ETU) @(posedge mclk_i);
    end
    drv_low <= 1'b0;
    repeat (stops * ETU) @(posedge mclk_i);
  endtask
endmodule

// ===== sim/sc_uart_properties.sv
`timescale 1ns/1ps
module sc_uart_checker (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // card line
  input wire logic io_i,
  input wire logic io_o,
  input wire logic io_oe_o
);
  logic [7:0] ctrl_q, ctrl_d, etu_q, etu_d;
  logic q_q, q_d, fresh_q, fresh_d, ctl_wr, st_rd, iso_rd, iso_wr;
  logic [15:0] cnt_q, cnt_d;
  assign ctl_wr = wr_i && addr_i == sc_pkg::CTRL_OFS;
  assign st_rd = rd_i && addr_i == sc_pkg::STAT_OFS;
  assign iso_rd = rd_i && addr_i == sc_pkg::ISO_OFS;
  assign iso_wr = wr_i && addr_i == sc_pkg::ISO_OFS;
  // frames launched from a queue write until the next control write are not length checked
  always_comb begin
    ctrl_d = ctl_wr ? wdata_i : ctrl_q;
    etu_d = (wr_i && addr_i == sc_pkg::ETU_OFS) ? wdata_i : etu_q;
    q_d = (wr_i && addr_i == sc_pkg::QUEUE_OFS) || (q_q && !ctl_wr);
    fresh_d = fresh_q && !wr_i && io_i;
    cnt_d = io_oe_o ? cnt_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ctrl_q <= sc_pkg::CTRL_RST;
      etu_q <= sc_pkg::ETU_RST;
      q_q <= 1'b0;
      fresh_q <= 1'b1;
      cnt_q <= 16'h0000;
    end else begin
      ctrl_q <= ctrl_d;
      etu_q <= etu_d;
      q_q <= q_d;
      fresh_q <= fresh_d;
      cnt_q <= cnt_d;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  property p_reset_out;
    $rose(resetn_i) |-> !io_oe_o && io_o && rdata_o == 8'h00;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");
  property p_fresh_stat;
    fresh_q && st_rd |=> rdata_o[6:0] == 7'h00;
  endproperty
  a_fresh_stat: assert property (p_fresh_stat) else $error("flag set with no event");
  property p_read_idle;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");
  property p_launch;
    wr_i && addr_i == sc_pkg::DATA_OFS && ctrl_q[sc_pkg::CT_TE] && ctrl_q[sc_pkg::CT_DIR]
      && !io_oe_o && !$past(wr_i) |-> ##[2:80] (io_oe_o && !io_o);
  endproperty
  a_launch: assert property (p_launch) else $error("no start bit after data write");
  property p_frame_len;
    $fell(io_oe_o) && !q_q |-> cnt_q == {8'h00, etu_q} * 16'h000a;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("tx frame length wrong");
  property p_tc_clear;
    st_rd ##1 (rdata_o[sc_pkg::ST_TC] && wr_i && addr_i == sc_pkg::DATA_OFS) ##1 st_rd
      |=> !rdata_o[sc_pkg::ST_TC];
  endproperty
  a_tc_clear: assert property (p_tc_clear) else $error("tx complete not cleared");
  property p_fe_clear;
    st_rd ##1 (rdata_o[sc_pkg::ST_FE] && rd_i && addr_i == sc_pkg::DATA_OFS) ##1 st_rd
      |=> rdata_o[2:0] == 3'h0;
  endproperty
  a_fe_clear: assert property (p_fe_clear) else $error("error flags not cleared");
  property p_nack_keep;
    iso_rd ##1 (rdata_o[sc_pkg::ISO_NACKT] && iso_wr && !wdata_i[sc_pkg::ISO_NACKT]) ##1 iso_rd
      |=> rdata_o[sc_pkg::ISO_NACKT];
  endproperty
  a_nack_keep: assert property (p_nack_keep) else $error("zero write cleared flag");
  property p_nack_clr;
    iso_rd ##1 (rdata_o[sc_pkg::ISO_NACKT] && iso_wr && wdata_i[sc_pkg::ISO_NACKT]) ##1 iso_rd
      |=> !rdata_o[sc_pkg::ISO_NACKT];
  endproperty
  a_nack_clr: assert property (p_nack_clr) else $error("one write kept flag");
  c_frame: cover property ($fell(io_oe_o) && !q_q);
  c_nack_clr: cover property (iso_wr && wdata_i[sc_pkg::ISO_NACKT]);
  c_fe_clr: cover property (rd_i && addr_i == sc_pkg::DATA_OFS && $past(st_rd));
endmodule
bind sc_uart sc_uart_checker chk_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .io_i(io_i), .io_o(io_o),
  .io_oe_o(io_oe_o));

// ===== sim/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module testbench;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o, d;
  logic io_i, io_o, io_oe_o;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  sc_uart dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o));
  card_model card_u (.mclk_i(mclk_i), .io_o(io_o), .io_oe_o(io_oe_o), .io_i(io_i));
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, string nm);
    logic [7:0] v;
    rd(a, v);
    `CHK(nm, v & m, e)
  endtask
  task automatic poll(input int b, output int k);
    logic [7:0] v;
    k = 0;
    do begin
      rd(sc_pkg::STAT_OFS, v);
      k++;
    end while (v[b] !== 1'b1 && k < 3000);
    `CHK("status poll", v[b], 1'b1)
  endtask
  task automatic wait_oe(input logic lvl);
    int k;
    k = 0;
    while (io_oe_o !== lvl && k < 400) begin
      @(posedge mclk_i);
      k++;
    end
  endtask
  // one byte: wait empty, write, let the frame pass, count polls to complete
  task automatic send_byte(input logic [7:0] v, output int k);
    poll(sc_pkg::ST_TRANSMIT_BUFFER_EMPTY_FLAG, k);
    wr(sc_pkg::DATA_OFS, v);
    rc(sc_pkg::STAT_OFS, 8'h40, 8'h00, "tc cleared");
    wait_oe(1'b1);
    wait_oe(1'b0);
    poll(sc_pkg::ST_TC, k);
  endtask
  // receiver reports a few clocks after the card's last stop etu when the card sends as many stop etus as the receiver checks
  task automatic rx_byte(input logic [7:0] v, input logic inv, input logic bad, input int stops);
    card_u.send(v, inv, bad, stops);
    repeat (8) @(posedge mclk_i);
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rc(sc_pkg::STAT_OFS, 8'h7f, 8'h00, "status");
    rc(sc_pkg::ISO_OFS, 8'h01, 8'h00, "nack flag");
    rc(sc_pkg::ETU_OFS, 8'hff, sc_pkg::ETU_RST, "etu");
    rc(sc_pkg::NLIM_OFS, 8'hff, sc_pkg::NLIM_RST, "nack limit");
    wr(3'h7, 8'hff);
    rc(3'h7, 8'hff, 8'h00, "unmapped");
    rc(sc_pkg::CTRL_OFS, 8'hff, sc_pkg::CTRL_RST, "ctrl");
    wr(sc_pkg::CTRL_OFS, 8'h02);
    rx_byte(8'h3b, 1'b0, 1'b0, 1);
    rc(sc_pkg::DATA_OFS, 8'hff, 8'h3b, "direct ts");
    rx_byte(8'h3f, 1'b1, 1'b0, 2);
    rc(sc_pkg::DATA_OFS, 8'hff, 8'h03, "inverse ts");
    wr(sc_pkg::CTRL_OFS, 8'h3e);
    rx_byte(8'h5a, 1'b1, 1'b0, 2);
    rc(sc_pkg::DATA_OFS, 8'hff, 8'h5a, "inverse data");
    wr(sc_pkg::CTRL_OFS, 8'h00);
    wr(sc_pkg::CTRL_OFS, 8'h04);
    wr(sc_pkg::CTRL_OFS, 8'h05);
    wr(sc_pkg::CTRL_OFS, 8'h07);
    send_byte(8'ha5, n);
    `CHK("tx frame", card_u.rx_sh, {1'b0, 8'ha5, 1'b0})
    card_u.nack_en = 1'b1;
    wr(sc_pkg::NLIM_OFS, 8'h02);
    send_byte(8'h11, n);
    `CHK("tc on nack", n < 20, 1'b1)
    rc(sc_pkg::ISO_OFS, 8'h01, 8'h00, "below limit");
    send_byte(8'h22, n);
    rc(sc_pkg::ISO_OFS, 8'h01, 8'h01, "at limit");
    wr(sc_pkg::ISO_OFS, 8'h00);
    rc(sc_pkg::ISO_OFS, 8'h01, 8'h01, "zero write");
    wr(sc_pkg::ISO_OFS, 8'h01);
    rc(sc_pkg::ISO_OFS, 8'h01, 8'h00, "one write");
    wr(sc_pkg::CTRL_OFS, 8'h06);
    wr(sc_pkg::CTRL_OFS, 8'h07);
    send_byte(8'h33, n);
    rc(sc_pkg::ISO_OFS, 8'h01, 8'h00, "count restarted");
    card_u.nack_en = 1'b0;
    rd(sc_pkg::STAT_OFS, d);
    wr(sc_pkg::QUEUE_OFS, 8'h01);
    wr(sc_pkg::DATA_OFS, 8'h44);
    repeat (600) @(posedge mclk_i);
    wr(sc_pkg::DATA_OFS, 8'h55);
    rc(sc_pkg::STAT_OFS, 8'h40, 8'h00, "tc without status read");
    wait_oe(1'b1);
    wait_oe(1'b0);
    poll(sc_pkg::ST_TC, n);
    wr(sc_pkg::CTRL_OFS, 8'h45);
    send_byte(8'h3c, n);
    `CHK("single stop", n < 20, 1'b1)
    `CHK("t1 frame", card_u.rx_sh, {1'b0, 8'h3c, 1'b0})
    wr(sc_pkg::CTRL_OFS, 8'h42);
    rx_byte(8'h66, 1'b0, 1'b0, 2);
    rc(sc_pkg::DATA_OFS, 8'hff, 8'h66, "twelve etu char");
    card_u.send(8'h77, 1'b0, 1'b0, 1);
    card_u.send(8'h0f, 1'b0, 1'b0, 2);
    repeat (320) @(posedge mclk_i);
    rd(sc_pkg::DATA_OFS, d);
    rx_byte(8'h48, 1'b0, 1'b1, 2);
    rc(sc_pkg::STAT_OFS, 8'h22, 8'h02, "framing, char dropped");
    rd(sc_pkg::DATA_OFS, d);
    `CHK("dropped data", d, 8'h66)
    rc(sc_pkg::STAT_OFS, 8'h07, 8'h00, "flags cleared");
    rx_byte(8'h5c, 1'b0, 1'b0, 2);
    rc(sc_pkg::DATA_OFS, 8'hff, 8'h5c, "receive resumes");
    wrap_up();
  end
endmodule
